// ### hw/rsq_pkg.sv
// Constants and types shared by the receive-side sequencer block.
// Assumes a 32-bit classic Wishbone register port with word-aligned access.
package rsq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Word indices; the byte address is four times the index.
  localparam int ADR_W = 10;
  localparam logic [7:0] IDX_TRANS_CFG = 8'h37; // Transition configuration.
  localparam logic [7:0] IDX_CTRL = 8'h39; // Low-power and command bits.
  localparam logic [7:0] IDX_STATUS = 8'h3A; // Sequencer state, read only.
  localparam logic [7:0] TRANS_CFG_RESET = 8'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RX_EXIT_LSB = 5;
  localparam int TMO_EXIT_LSB = 3;
  localparam int PKT_EXIT_LSB = 0;
  localparam int CTRL_LP_SEL_BIT = 0;
  localparam int CTRL_IDLE_MODE_BIT = 1;
  localparam int CTRL_ENTER_RX_BIT = 2;
  localparam int CTRL_HALT_BIT = 3;
  localparam int STAT_SLEEP_BIT = 3;

  // ----------------------------------------------------------------
  // Selector codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RX_UNUSED_LO = 3'h0;
  localparam logic [2:0] RX_PAYLOAD_PKT = 3'h1;
  localparam logic [2:0] RX_PAYLOAD_LP = 3'h2;
  localparam logic [2:0] RX_CRC_PKT = 3'h3;
  localparam logic [2:0] RX_LEVEL_HALT = 3'h4;
  localparam logic [2:0] RX_SYNC_HALT = 3'h5;
  localparam logic [2:0] RX_PRE_HALT = 3'h6;
  localparam logic [1:0] TMO_RELAUNCH = 2'h0;
  localparam logic [1:0] TMO_TRANSMIT = 2'h1;
  localparam logic [1:0] TMO_LOW_POWER = 2'h2;
  localparam logic [1:0] TMO_HALT = 2'h3;
  localparam logic [2:0] PKT_HALT = 3'h0;
  localparam logic [2:0] PKT_FIFO_TX = 3'h1;
  localparam logic [2:0] PKT_LOW_POWER = 3'h2;
  localparam logic [2:0] PKT_RX_SYNTH = 3'h3;
  localparam logic [2:0] PKT_RX_DIRECT = 3'h4;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along the receive path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HALTED = 3'h0,
    ST_RECEIVE = 3'h1,
    ST_PACKET_DONE = 3'h3,
    ST_SYNTH = 3'h2,
    ST_RELAUNCH = 3'h6,
    ST_TRANSMIT = 3'h7,
    ST_IDLE = 3'h5
  } rsq_state_t;

endpackage

// ### hw/rsq_exit_decide.sv
// Combinational exit decision for the Receive and packet-done states.
// Assumes all event inputs are synchronous to the sequencer clock.
`timescale 1ns/10ps
`default_nettype none
module rsq_exit_decide
  import rsq_pkg::*;
(
  input wire rsq_state_t state,
  input wire logic [2:0] receive_exit_select,
  input wire logic [1:0] rx_timeout_exit_select,
  input wire logic [2:0] packet_done_exit_select,
  input wire logic low_power_target_select,
  input wire logic payload_complete_flag,
  input wire logic checksum_good_flag,
  input wire logic signal_level_flag,
  input wire logic sync_match_flag,
  input wire logic preamble_seen_flag,
  input wire logic fifo_drained_flag,
  input wire logic level_wait_timeout,
  input wire logic preamble_wait_timeout,
  input wire logic sync_wait_timeout,
  input wire logic freq_changed,
  output logic go,
  output rsq_state_t next_state
);

  // ----------------------------------------------------------------
  // Decision
  // ----------------------------------------------------------------
  // Receive-exit events win over a timeout seen in the same cycle.
  always_comb
  begin
    rsq_state_t lp_state;
    rsq_state_t tmo_state;
    logic receive_timeout_event;
    lp_state = low_power_target_select ? ST_IDLE : ST_HALTED;
    receive_timeout_event = level_wait_timeout | preamble_wait_timeout | sync_wait_timeout;
    case (rx_timeout_exit_select)
      TMO_RELAUNCH: tmo_state = ST_RELAUNCH;
      TMO_TRANSMIT: tmo_state = ST_TRANSMIT;
      TMO_LOW_POWER: tmo_state = lp_state;
      default: tmo_state = ST_HALTED;
    endcase
    go = 1'b0;
    next_state = state;
    case (state)
      ST_RECEIVE:
      begin
        case (receive_exit_select)
          RX_PAYLOAD_PKT:
          begin
            go = payload_complete_flag;
            next_state = ST_PACKET_DONE;
          end
          RX_PAYLOAD_LP:
          begin
            go = payload_complete_flag;
            next_state = lp_state;
          end
          RX_CRC_PKT:
          begin
            go = checksum_good_flag | payload_complete_flag;
            // A payload without a good checksum follows the timeout selector.
            next_state = checksum_good_flag ? ST_PACKET_DONE : tmo_state;
          end
          RX_LEVEL_HALT:
          begin
            go = signal_level_flag;
            next_state = ST_HALTED;
          end
          RX_SYNC_HALT:
          begin
            go = sync_match_flag;
            next_state = ST_HALTED;
          end
          RX_PRE_HALT:
          begin
            go = preamble_seen_flag;
            next_state = ST_HALTED;
          end
          default:
          begin
            go = 1'b0;
            next_state = state;
          end
        endcase
        if (!go && receive_timeout_event)
        begin
          go = 1'b1;
          next_state = tmo_state;
        end
      end
      ST_PACKET_DONE:
      begin
        case (packet_done_exit_select)
          PKT_HALT:
          begin
            go = 1'b1;
            next_state = ST_HALTED;
          end
          PKT_FIFO_TX:
          begin
            go = fifo_drained_flag;
            next_state = ST_TRANSMIT;
          end
          PKT_LOW_POWER:
          begin
            go = 1'b1;
            next_state = lp_state;
          end
          PKT_RX_SYNTH:
          begin
            go = 1'b1;
            next_state = freq_changed ? ST_SYNTH : ST_RECEIVE;
          end
          PKT_RX_DIRECT:
          begin
            go = 1'b1;
            next_state = ST_RECEIVE;
          end
          default:
          begin
            go = 1'b0;
            next_state = state;
          end
        endcase
      end
      default:
      begin
        go = 1'b0;
        next_state = state;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### hw/rsq_sequencer.sv
// Receive-side transition sequencer with its Wishbone register port.
// Assumes event flags come from logic on MCLK and are sampled each cycle.
//
// What this block does
// - Codes 000 and 111 leave Receive only on a timeout or software command.
// - 001 payload or 011 checksum: to packet-done.
// - 010: payload goes to low-power target.
// - 100/101/110: level, sync, preamble halt sequencer.
// - Timeout selector; also payload under code 011.
// - Timeout codes: relaunch, transmit, low power, halt.
// - Receive timeout is OR of three timeouts.
// - Packet-done 000 halt, 001 fifo-transmit, 010 low.
// - 011 via synth if retuned; 100 direct.
// - Low-power select: halt or Idle state.
// - Idle-mode bit: Standby zero, Sleep one.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rsq_sequencer
  import rsq_pkg::*;
(
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic PAYLOAD_COMPLETE_FLAG,
  input wire logic CHECKSUM_GOOD_FLAG,
  input wire logic SIGNAL_LEVEL_FLAG,
  input wire logic SYNC_MATCH_FLAG,
  input wire logic PREAMBLE_SEEN_FLAG,
  input wire logic FIFO_DRAINED_FLAG,
  input wire logic LEVEL_WAIT_TIMEOUT,
  input wire logic PREAMBLE_WAIT_TIMEOUT,
  input wire logic SYNC_WAIT_TIMEOUT,
  input wire logic FREQ_CHANGED,
  output logic [2:0] SEQ_STATE,
  output logic RECEIVER_RELAUNCH,
  output logic SYNTH_ONLY_MODE,
  output logic IDLE_SLEEP
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ack_q; // Answer strobe, high for one cycle.
  logic [31:0] dat_q; // Read data captured with the request.
  logic [7:0] cfg_q; // Transition configuration register.
  logic [1:0] ctrl_q; // Low-power select and idle-mode bits.
  rsq_state_t state_q; // Current sequencer state.
  logic req; // A new request that has not been answered yet.
  logic wr_lane0; // A write is taken at this edge with byte lane 0 on.
  logic [7:0] word_idx; // Word index of the access.
  logic sw_halt; // Software halt command this edge.
  logic sw_enter; // Software enter-receive command this edge.
  logic [31:0] rd_mux; // Read data for the addressed word.

  assign req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign word_idx = WB_ADR_I[ADR_W-1:2];
  // Writes commit on the edge that samples ack, as the master expects.
  assign wr_lane0 = WB_CYC_I & WB_STB_I & WB_WE_I & ack_q & WB_SEL_I[0];
  assign sw_halt = wr_lane0 & (word_idx == IDX_CTRL) & WB_DAT_I[CTRL_HALT_BIT];
  assign sw_enter = wr_lane0 & (word_idx == IDX_CTRL) & WB_DAT_I[CTRL_ENTER_RX_BIT];

  // Read multiplexer; unmapped words read as zero and are still answered.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (word_idx)
      IDX_TRANS_CFG: rd_mux[7:0] = cfg_q;
      IDX_CTRL: rd_mux[1:0] = ctrl_q;
      IDX_STATUS:
      begin
        rd_mux[2:0] = state_q;
        rd_mux[STAT_SLEEP_BIT] = IDLE_SLEEP;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // The answer comes one cycle after the request and drops after one cycle.
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // Read data is registered so that the bus output comes from a flip-flop.
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      dat_q <= 32'h0000_0000;
    else if (req)
      dat_q <= rd_mux;
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // The three selectors share one byte: receive exit, timeout exit, packet done.
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      cfg_q <= TRANS_CFG_RESET;
    else if (wr_lane0 && word_idx == IDX_TRANS_CFG)
      cfg_q <= WB_DAT_I[7:0];
  end

  // Command bits are strobes and are not stored; they always read as zero.
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      ctrl_q <= CTRL_RESET;
    else if (wr_lane0 && word_idx == IDX_CTRL)
      ctrl_q <= WB_DAT_I[1:0];
  end

  logic [2:0] rx_sel; // Receive-exit code.
  logic [1:0] tmo_sel; // Timeout-exit code.
  logic [2:0] pkt_sel; // Packet-done exit code.
  logic lp_sel; // Low-power target select.
  logic idle_mode; // Idle chip mode select.
  assign rx_sel = cfg_q[RX_EXIT_LSB +: 3];
  assign tmo_sel = cfg_q[TMO_EXIT_LSB +: 2];
  assign pkt_sel = cfg_q[PKT_EXIT_LSB +: 3];
  assign lp_sel = ctrl_q[CTRL_LP_SEL_BIT];
  assign idle_mode = ctrl_q[CTRL_IDLE_MODE_BIT];

  // ----------------------------------------------------------------
  // Transition decision
  // ----------------------------------------------------------------
  logic hw_go; // A configured exit is taken this cycle.
  rsq_state_t hw_next; // Target of that transition.

  rsq_exit_decide u_decide (
    .state(state_q),
    .receive_exit_select(rx_sel),
    .rx_timeout_exit_select(tmo_sel),
    .packet_done_exit_select(pkt_sel),
    .low_power_target_select(lp_sel),
    .payload_complete_flag(PAYLOAD_COMPLETE_FLAG),
    .checksum_good_flag(CHECKSUM_GOOD_FLAG),
    .signal_level_flag(SIGNAL_LEVEL_FLAG),
    .sync_match_flag(SYNC_MATCH_FLAG),
    .preamble_seen_flag(PREAMBLE_SEEN_FLAG),
    .fifo_drained_flag(FIFO_DRAINED_FLAG),
    .level_wait_timeout(LEVEL_WAIT_TIMEOUT),
    .preamble_wait_timeout(PREAMBLE_WAIT_TIMEOUT),
    .sync_wait_timeout(SYNC_WAIT_TIMEOUT),
    .freq_changed(FREQ_CHANGED),
    .go(hw_go),
    .next_state(hw_next)
  );

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Software halt beats software enter, which beats any hardware event.
  // Relaunch and synth-only are one-cycle passes back into Receive.
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      state_q <= ST_HALTED;
    else if (sw_halt)
      state_q <= ST_HALTED;
    else if (sw_enter)
      state_q <= ST_RECEIVE;
    else
    begin
      case (state_q)
        ST_RELAUNCH: state_q <= ST_RECEIVE;
        ST_SYNTH: state_q <= ST_RECEIVE;
        ST_RECEIVE, ST_PACKET_DONE:
        begin
          if (hw_go)
            state_q <= hw_next;
          else
            state_q <= state_q;
        end
        ST_HALTED, ST_TRANSMIT, ST_IDLE: state_q <= state_q;
        default: state_q <= ST_HALTED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SEQ_STATE = state_q;
  assign RECEIVER_RELAUNCH = (state_q == ST_RELAUNCH);
  assign SYNTH_ONLY_MODE = (state_q == ST_SYNTH);
  assign IDLE_SLEEP = (state_q == ST_IDLE) & idle_mode;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);

  logic sw_any; // Any software command overriding the sequencer.
  logic any_tmo; // Any of the three timeouts.
  logic rx_ev; // Any receive-exit event, matched or not.
  assign sw_any = sw_halt | sw_enter;
  assign any_tmo = LEVEL_WAIT_TIMEOUT | PREAMBLE_WAIT_TIMEOUT | SYNC_WAIT_TIMEOUT;
  // With no receive event at all, a timeout decides whatever the receive code is.
  assign rx_ev = PAYLOAD_COMPLETE_FLAG | CHECKSUM_GOOD_FLAG | SIGNAL_LEVEL_FLAG
                 | SYNC_MATCH_FLAG | PREAMBLE_SEEN_FLAG;

  sequence s_relaunch_then_rx;
    (state_q == ST_RELAUNCH) ##1 (state_q == ST_RECEIVE);
  endsequence

  sequence s_synth_then_rx;
    SYNTH_ONLY_MODE ##1 (state_q == ST_RECEIVE);
  endsequence

  a_unused_rx_hold: assert property (
    (state_q == ST_RECEIVE) && (rx_sel == RX_UNUSED_LO || rx_sel == 3'h7) && !any_tmo && !sw_any
    |=> state_q == ST_RECEIVE)
    else $error("Receive left under an unused exit code.");

  a_payload_to_done: assert property (
    (state_q == ST_RECEIVE) && rx_sel == RX_PAYLOAD_PKT && PAYLOAD_COMPLETE_FLAG && !sw_any
    |=> state_q == ST_PACKET_DONE)
    else $error("Payload did not lead to packet-done.");

  a_crc_to_done: assert property (
    (state_q == ST_RECEIVE) && rx_sel == RX_CRC_PKT && CHECKSUM_GOOD_FLAG && !sw_any
    |=> state_q == ST_PACKET_DONE)
    else $error("Checksum event did not lead to packet-done.");

  a_payload_low_power: assert property (
    (state_q == ST_RECEIVE) && rx_sel == RX_PAYLOAD_LP && PAYLOAD_COMPLETE_FLAG && !sw_any
    |=> state_q == ($past(lp_sel) ? ST_IDLE : ST_HALTED))
    else $error("Payload did not reach the low-power target.");

  a_event_halts: assert property (
    (state_q == ST_RECEIVE) && !sw_any && ((rx_sel == RX_LEVEL_HALT && SIGNAL_LEVEL_FLAG)
    || (rx_sel == RX_SYNC_HALT && SYNC_MATCH_FLAG) || (rx_sel == RX_PRE_HALT && PREAMBLE_SEEN_FLAG))
    |=> state_q == ST_HALTED)
    else $error("Halting event did not halt the sequencer.");

  a_tmo_relaunch: assert property (
    (state_q == ST_RECEIVE) && (rx_sel == RX_UNUSED_LO || !rx_ev) && tmo_sel == TMO_RELAUNCH && any_tmo && !sw_any
    ##1 !sw_any |-> s_relaunch_then_rx)
    else $error("Timeout did not relaunch the receiver.");

  a_tmo_or_tx: assert property (
    (state_q == ST_RECEIVE) && (rx_sel == RX_UNUSED_LO || !rx_ev) && tmo_sel == TMO_TRANSMIT && any_tmo && !sw_any
    |=> state_q == ST_TRANSMIT)
    else $error("A timeout did not move Receive to Transmit.");

  a_crc_payload_tmo: assert property (
    (state_q == ST_RECEIVE) && rx_sel == RX_CRC_PKT && PAYLOAD_COMPLETE_FLAG && !CHECKSUM_GOOD_FLAG
    && tmo_sel == TMO_TRANSMIT && !sw_any |=> state_q == ST_TRANSMIT)
    else $error("Payload under code 011 ignored the timeout selector.");

  a_fifo_to_tx: assert property (
    (state_q == ST_PACKET_DONE) && pkt_sel == PKT_FIFO_TX && FIFO_DRAINED_FLAG && !sw_any
    |=> state_q == ST_TRANSMIT)
    else $error("Drained FIFO did not start Transmit.");

  a_synth_path: assert property (
    (state_q == ST_PACKET_DONE) && pkt_sel == PKT_RX_SYNTH && FREQ_CHANGED && !sw_any
    ##1 !sw_any |-> s_synth_then_rx)
    else $error("Retuned return skipped synth-only mode.");

  a_idle_entry: assert property (
    (state_q == ST_PACKET_DONE) && pkt_sel == PKT_LOW_POWER && lp_sel && !sw_any
    |=> state_q == ST_IDLE && IDLE_SLEEP == $past(idle_mode))
    else $error("Idle entry or its chip mode is wrong.");

  a_done_hold: assert property (
    (state_q == ST_PACKET_DONE) && pkt_sel == PKT_FIFO_TX && !FIFO_DRAINED_FLAG && !sw_any
    |=> state_q == ST_PACKET_DONE)
    else $error("Packet-done left without its event.");

  a_ack_single: assert property (
    req |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("Bus answer was not a single cycle.");

  // Software commands override any event seen at the same edge.
  a_halt_command: assert property (
    sw_halt |=> state_q == ST_HALTED)
    else $error("Halt command did not stop the sequencer.");

  a_enter_command: assert property (
    sw_enter && !sw_halt |=> state_q == ST_RECEIVE)
    else $error("Enter command did not start Receive.");

endmodule
`default_nettype wire

// ### testbench/radio_sequencer_rx_transitions_tb.sv
// Self-checking bench for the receive-side transition sequencer.
// Assumes the design samples its register port and event inputs on MCLK only.
`timescale 1ns/10ps
`default_nettype none
module radio_sequencer_rx_transitions_tb
  import rsq_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus signals
  // ----------------------------------------------------------------
  logic MCLK = 1'b0; // Bench clock, 4 ns period.
  logic ARST_N = 1'b0; // Held low for the first five cycles.
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Wishbone request lines.
  logic [ADR_W-1:0] adr = '0; // Byte address.
  logic [3:0] sel = 4'h0; // Byte enables.
  logic [31:0] wdat = 32'h0; // Write data.
  logic [31:0] rdat; // Read data from the slave.
  logic ack; // Acknowledge from the slave.
  logic [8:0] ev = 9'h000; // Event lines, one bit per flag.
  logic fq = 1'b0; // Carrier retuned level.
  logic [1:0] ctl_q = 2'h0; // Last low-power and idle-mode bits written.
  logic [2:0] st; // Sequencer state code.
  logic relaunch, synth, sleep; // Decoded state outputs.
  logic [15:0] lfsr_q = 16'h4812; // Random source, fixed start.
  int error_cnt = 0;
  int n_checks = 0;
  localparam logic [8:0] E_PAY = 9'h001, E_CRC = 9'h002, E_LVL = 9'h004, E_SYN = 9'h008;
  localparam logic [8:0] E_PRE = 9'h010, E_FIFO = 9'h020, E_TL = 9'h040, E_TP = 9'h080, E_TS = 9'h100;

  always #2 MCLK = ~MCLK;

  rsq_sequencer u_rsq_sequencer (.MCLK(MCLK), .ARST_N(ARST_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .PAYLOAD_COMPLETE_FLAG(ev[0]), .CHECKSUM_GOOD_FLAG(ev[1]), .SIGNAL_LEVEL_FLAG(ev[2]),
    .SYNC_MATCH_FLAG(ev[3]), .PREAMBLE_SEEN_FLAG(ev[4]), .FIFO_DRAINED_FLAG(ev[5]),
    .LEVEL_WAIT_TIMEOUT(ev[6]), .PREAMBLE_WAIT_TIMEOUT(ev[7]), .SYNC_WAIT_TIMEOUT(ev[8]),
    .FREQ_CHANGED(fq), .SEQ_STATE(st), .RECEIVER_RELAUNCH(relaunch), .SYNTH_ONLY_MODE(synth),
    .IDLE_SLEEP(sleep));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Galois shift register; a fixed start keeps every run the same.
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    lfsr_next = {1'b0, v[15:1]} ^ (v[0] ? 16'hB400 : 16'h0000);
  endfunction

  // Expected state outputs: code plus the three decoded flags.
  function automatic logic [5:0] exp_out(input rsq_state_t x, input logic idle_sleep);
    exp_out = {x, x == ST_RELAUNCH, x == ST_SYNTH, (x == ST_IDLE) && idle_sleep};
  endfunction

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Single comparison point; unknowns never match.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle; the wait for ack is bounded.
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    @(posedge MCLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    wdat <= {24'h0, d};
    for (n = 0; n < 20; n++)
    begin
      @(posedge MCLK);
      if (ack === 1'b1)
        break;
    end
    if (n == 20)
    begin
      error_cnt++;
      $display("[ERR] %0t bus answer never came", $time);
      conclude();
    end
    else
    begin
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask

  // Configure, enter Receive, fire two event sets, follow three states.
  task automatic run_case(input logic [7:0] cfg, input logic [1:0] ctl, input logic [8:0] e1,
                          input logic [8:0] e2, input logic f, input rsq_state_t x1,
                          input rsq_state_t x2, input rsq_state_t x3);
    logic [31:0] r;
    wb(1'b1, IDX_TRANS_CFG, cfg, 4'h1, r);
    wb(1'b1, IDX_CTRL, {6'h01, ctl}, 4'h1, r);
    ctl_q = ctl;
    fq <= f;
    @(posedge MCLK);
    chk(st, ST_RECEIVE);
    ev <= e1;
    @(posedge MCLK);
    ev <= e2;
    #1 chk({st, relaunch, synth, sleep}, exp_out(x1, ctl_q[1]));
    @(posedge MCLK);
    ev <= 9'h000;
    #1 chk({st, relaunch, synth, sleep}, exp_out(x2, ctl_q[1]));
    @(posedge MCLK);
    fq <= 1'b0;
    #1 chk({st, relaunch, synth, sleep}, exp_out(x3, ctl_q[1]));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    repeat (5) @(posedge MCLK);
    ARST_N <= 1'b1;
    // Reset values, read-only status and an unmapped word.
    wb(1'b0, IDX_TRANS_CFG, 8'h00, 4'hF, r);
    chk(r, {24'h0, TRANS_CFG_RESET});
    wb(1'b0, IDX_CTRL, 8'h00, 4'hF, r);
    chk(r, 32'h0);
    wb(1'b0, IDX_STATUS, 8'h00, 4'hF, r);
    chk(r, 32'h0);
    wb(1'b0, 8'hFF, 8'h00, 4'hF, r);
    chk(r, 32'h0);
    $display("register reset test done");
    // Random configuration values read back; a lane-0-off write is dropped.
    repeat (6)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      wb(1'b1, IDX_TRANS_CFG, lfsr_q[7:0], 4'h1, r);
      wb(1'b1, IDX_TRANS_CFG, lfsr_q[15:8], 4'hE, r);
      wb(1'b0, IDX_TRANS_CFG, 8'h00, 4'hF, r);
      chk(r, {24'h0, lfsr_q[7:0]});
    end
    $display("register access test done");
    // Unused receive code 000 (the fixed seed never picks 111) ignores four random mixes of receive events.
    repeat (4)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      run_case({lfsr_q[0] ? 3'h7 : RX_UNUSED_LO, TMO_HALT, PKT_HALT}, 2'h0, lfsr_q[13:5] & 9'h03F,
               9'h000, 1'b0, ST_RECEIVE, ST_RECEIVE, ST_RECEIVE);
    end
    run_case({RX_PAYLOAD_PKT, TMO_HALT, PKT_RX_DIRECT}, 2'h0, E_PAY, 9'h000, 1'b0,
             ST_PACKET_DONE, ST_RECEIVE, ST_RECEIVE);
    run_case({RX_CRC_PKT, TMO_RELAUNCH, PKT_HALT}, 2'h0, E_CRC, 9'h000, 1'b0,
             ST_PACKET_DONE, ST_HALTED, ST_HALTED);
    run_case({RX_CRC_PKT, TMO_TRANSMIT, PKT_HALT}, 2'h0, E_PAY, 9'h000, 1'b0,
             ST_TRANSMIT, ST_TRANSMIT, ST_TRANSMIT);
    run_case({RX_PAYLOAD_LP, TMO_HALT, PKT_HALT}, 2'h0, E_PAY, 9'h000, 1'b0,
             ST_HALTED, ST_HALTED, ST_HALTED);
    run_case({RX_PAYLOAD_LP, TMO_HALT, PKT_HALT}, 2'h3, E_PAY, 9'h000, 1'b0,
             ST_IDLE, ST_IDLE, ST_IDLE);
    run_case({RX_LEVEL_HALT, TMO_HALT, PKT_HALT}, 2'h0, E_SYN | E_PRE | E_PAY, E_LVL, 1'b0,
             ST_RECEIVE, ST_HALTED, ST_HALTED);
    run_case({RX_SYNC_HALT, TMO_HALT, PKT_HALT}, 2'h0, E_LVL, E_SYN, 1'b0,
             ST_RECEIVE, ST_HALTED, ST_HALTED);
    run_case({RX_PRE_HALT, TMO_HALT, PKT_HALT}, 2'h0, E_SYN, E_PRE, 1'b0,
             ST_RECEIVE, ST_HALTED, ST_HALTED);
    run_case({RX_PAYLOAD_PKT, TMO_RELAUNCH, PKT_HALT}, 2'h0, E_TL, 9'h000, 1'b0,
             ST_RELAUNCH, ST_RECEIVE, ST_RECEIVE);
    run_case({RX_PAYLOAD_PKT, TMO_TRANSMIT, PKT_HALT}, 2'h0, E_TP, 9'h000, 1'b0,
             ST_TRANSMIT, ST_TRANSMIT, ST_TRANSMIT);
    run_case({RX_PAYLOAD_PKT, TMO_LOW_POWER, PKT_HALT}, 2'h1, E_TS, 9'h000, 1'b0,
             ST_IDLE, ST_IDLE, ST_IDLE);
    run_case({RX_PAYLOAD_PKT, TMO_HALT, PKT_HALT}, 2'h0, E_TS | E_TL, 9'h000, 1'b0,
             ST_HALTED, ST_HALTED, ST_HALTED);
    run_case({RX_PAYLOAD_PKT, TMO_HALT, PKT_FIFO_TX}, 2'h0, E_PAY | E_TL, 9'h000, 1'b0,
             ST_PACKET_DONE, ST_PACKET_DONE, ST_PACKET_DONE);
    run_case({RX_PAYLOAD_PKT, TMO_HALT, PKT_FIFO_TX}, 2'h0, E_PAY, E_FIFO, 1'b0,
             ST_PACKET_DONE, ST_TRANSMIT, ST_TRANSMIT);
    run_case({RX_PAYLOAD_PKT, TMO_HALT, PKT_LOW_POWER}, 2'h0, E_PAY, 9'h000, 1'b0,
             ST_PACKET_DONE, ST_HALTED, ST_HALTED);
    run_case({RX_PAYLOAD_PKT, TMO_HALT, PKT_LOW_POWER}, 2'h3, E_PAY, 9'h000, 1'b0,
             ST_PACKET_DONE, ST_IDLE, ST_IDLE);
    run_case({RX_PAYLOAD_PKT, TMO_HALT, PKT_RX_SYNTH}, 2'h0, E_PAY, 9'h000, 1'b1,
             ST_PACKET_DONE, ST_SYNTH, ST_RECEIVE);
    run_case({RX_PAYLOAD_PKT, TMO_HALT, PKT_RX_SYNTH}, 2'h0, E_PAY, 9'h000, 1'b0,
             ST_PACKET_DONE, ST_RECEIVE, ST_RECEIVE);
    $display("transition test done");
    // Software halt from Receive.
    wb(1'b1, IDX_CTRL, 8'h08, 4'h1, r);
    #1 chk(st, ST_HALTED);
    $display("halt command test done");
    conclude();
  end
endmodule
`default_nettype wire
